// ===== scb_bank.sv
// Scrub channel configuration bank: setup, start and end registers for
// scrub channels 2 to 4, the channel 1 end register, and the per-channel
// control that those registers steer.
// Assumes the scrub engine, the trigger sources and the escalation
// prescaler sit on i_clk, so their inputs need no synchroniser.
//
// Decided for this implementation: strobed register access.
module scb_bank (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    // Register port
    input  wire logic [scb_pkg::AW-1:0]  i_addr,
    input  wire logic [scb_pkg::DW-1:0]  i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [scb_pkg::DW-1:0]  o_rdata,
    output logic                         o_irq,
    // Scrub engine side; in the per-channel vectors index 0 is channel 2
    input  wire logic [3:0]              i_trig_evt,
    input  wire logic                    i_esc_tick,
    input  wire logic [2:0]              i_ch_waiting,
    input  wire logic [2:0]              i_ch_at_page,
    input  wire logic [2:0]              i_ch_seq_done,
    input  wire logic [2:0][4:0]         i_ch_inflight,
    output logic      [2:0][4:0]         o_ch_cap,
    output logic      [2:0]              o_ch_issue_ok,
    output logic      [2:0]              o_ch_prio_up,
    output logic      [2:0]              o_ch_pause,
    output logic      [2:0][3:0]         o_ch_qos,
    output logic      [2:0]              o_ch_done_evt,
    output logic      [2:0]              o_ch_phys_mode,
    output logic      [2:0]              o_ch_start,
    output logic      [2:0][31:0]        o_ch_start_addr,
    output logic      [2:0][31:0]        o_ch_end_addr,
    output logic      [2:0][2:0]         o_ch_start_rank,
    output logic      [2:0][3:0]         o_ch_start_bank,
    output logic      [2:0][17:0]        o_ch_start_row,
    output logic      [2:0][2:0]         o_ch_end_rank,
    output logic      [2:0][3:0]         o_ch_end_bank,
    output logic      [2:0][17:0]        o_ch_end_row,
    output logic      [31:0]             o_ch1_end_addr
);
    import scb_pkg::*;

    scb_state_t s_q;
    scb_state_t s_d;

    // Next-state logic for the whole bank
    always_comb begin
        logic [4:0]  cap;
        logic [4:0]  cap_eff;
        logic [3:0]  esc;
        logic [11:0] base;
        logic [2:0]  clr;
        s_d = s_q;
        cap = 5'h00;
        cap_eff = 5'h00;
        esc = 4'h0;
        base = 12'h000;
        clr = 3'h0;

        // Register writes, allowed whatever the engine is doing
        if (i_wr) begin
            if (i_addr == OFS_CH1_END) begin
                s_d.ch1_end = i_wdata;
            end
            for (int c = 0; c < NCH; c++) begin
                base = 12'(OFS_CH2_SETUP + 12'(c) * OFS_CH_STRIDE);
                if (i_addr == base) begin
                    s_d.setup[c] = i_wdata & SETUP_MASK;
                end
                if (i_addr == 12'(base + 12'h004)) begin
                    s_d.rstart[c] = i_wdata;
                end
                if (i_addr == 12'(base + 12'h008)) begin
                    s_d.rend[c] = i_wdata;
                end
            end
            if (i_addr == OFS_EVT_EN) begin
                s_d.ien = i_wdata[2:0];
            end
            if (i_addr == OFS_EVT_CLR) begin
                clr = i_wdata[2:0];
            end
        end

        // Read data stands for one cycle only
        s_d.rdata = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                OFS_CH1_END:   s_d.rdata = s_q.ch1_end;
                OFS_CH2_SETUP: s_d.rdata = s_q.setup[0];
                OFS_CH2_START: s_d.rdata = s_q.rstart[0];
                OFS_CH2_END:   s_d.rdata = s_q.rend[0];
                OFS_CH3_SETUP: s_d.rdata = s_q.setup[1];
                OFS_CH3_START: s_d.rdata = s_q.rstart[1];
                OFS_CH3_END:   s_d.rdata = s_q.rend[1];
                OFS_CH4_SETUP: s_d.rdata = s_q.setup[2];
                OFS_CH4_START: s_d.rdata = s_q.rstart[2];
                OFS_CH4_END:   s_d.rdata = s_q.rend[2];
                OFS_EVT_STS:   s_d.rdata = {29'h0000_0000, s_q.sts};
                OFS_EVT_EN:    s_d.rdata = {29'h0000_0000, s_q.ien};
                default:       s_d.rdata = 32'h0000_0000; // Unmapped and clear reg
            endcase
        end

        // Per-channel control driven by the live setup words
        for (int c = 0; c < NCH; c++) begin
            cap = s_q.setup[c][CAP_LSB +: 5];
            esc = s_q.setup[c][ESC_LSB +: 4];
            // cap below 8 is unsupported, treated as 8
            cap_eff = (cap < CAP_MIN) ? CAP_MIN : cap;
            s_d.issue_ok[c] = i_ch_inflight[c] < cap_eff;

            if (!i_ch_waiting[c] || esc == 4'h0) begin
                s_d.esc_cnt[c] = 4'h0;
                s_d.prio_up[c] = 1'b0;
            end else if (i_esc_tick && !s_q.prio_up[c]) begin
                s_d.esc_cnt[c] = 4'(s_q.esc_cnt[c] + 4'h1);
                if (4'(s_q.esc_cnt[c] + 4'h1) >= esc) begin
                    s_d.prio_up[c] = 1'b1;
                end
            end

            s_d.pause[c] = s_q.setup[c][PAGE_BIT] & i_ch_at_page[c];

            s_d.start[c] = i_trig_evt[s_q.setup[c][TRIG_LSB +: 2]];

            // completion event gated by its enable
            s_d.done_evt[c] = s_q.setup[c][DONE_BIT] & i_ch_seq_done[c];
        end

        // Sticky status: a new event beats a clear in the same cycle
        s_d.sts = (s_q.sts & ~clr) | s_q.done_evt;
        s_d.irq = |(s_d.sts & s_d.ien);

        if (!i_rst_n) begin
            s_d = '0;
            for (int c = 0; c < NCH; c++) begin
                s_d.setup[c] = RST_SETUP;
                s_d.rstart[c] = RST_ADDR;
                s_d.rend[c] = RST_ADDR;
            end
            s_d.ch1_end = RST_ADDR;
        end
    end

    // State register, reset folded into the next value
    always_ff @(posedge i_clk) begin
        s_q <= s_d;
    end

    // Output map; every output is a flop or a slice of one
    assign o_rdata = s_q.rdata;
    assign o_irq = s_q.irq;
    assign o_ch_issue_ok = s_q.issue_ok;
    assign o_ch_prio_up = s_q.prio_up;
    assign o_ch_pause = s_q.pause;
    assign o_ch_start = s_q.start;
    assign o_ch_done_evt = s_q.done_evt;
    assign o_ch_start_addr = s_q.rstart;
    assign o_ch_end_addr = s_q.rend;
    assign o_ch1_end_addr = s_q.ch1_end;

    // Per-channel field fan-out; system mode consumers take the raw words
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign o_ch_cap[c] = s_q.setup[c][CAP_LSB +: 5];
        assign o_ch_qos[c] = s_q.setup[c][QOS_LSB +: 4];
        assign o_ch_phys_mode[c] = s_q.setup[c][MODE_BIT];
        assign o_ch_start_rank[c] = s_q.rstart[c][RANK_LSB +: 3];
        assign o_ch_start_bank[c] = s_q.rstart[c][BANK_LSB +: 4];
        assign o_ch_start_row[c] = s_q.rstart[c][ROW_LSB +: 18];
        assign o_ch_end_rank[c] = s_q.rend[c][RANK_LSB +: 3];
        assign o_ch_end_bank[c] = s_q.rend[c][BANK_LSB +: 4];
        assign o_ch_end_row[c] = s_q.rend[c][ROW_LSB +: 18];
    end : g_ch

    // Checks on the bank's own behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_setup_reset: assert property ($rose(i_rst_n) |-> s_q.setup[0] == 32'h1f00_0000)
        else $error("setup word not at reset value");
    a_setup_rsvd: assert property ((s_q.setup[1] & ~32'h1f0f_3e4b) == 32'h0)
        else $error("reserved setup bits set");
    a_setup_write: assert property (i_wr && i_addr == 12'h1a0 |=>
        s_q.setup[1] == ($past(i_wdata) & 32'h1f0f_3e4b))
        else $error("setup write lost");
    a_start_read: assert property (i_rd && i_addr == 12'h1b4 && !i_wr |=>
        o_rdata == $past(s_q.rstart[2]))
        else $error("start address read wrong");
    a_end_write: assert property (i_wr && i_addr == 12'h198 |=>
        o_ch_end_addr[0] == $past(i_wdata))
        else $error("end address write lost");
    a_issue_cap: assert property (i_ch_inflight[0] >= 5'd31 |=> !o_ch_issue_ok[0])
        else $error("issue allowed at cap");
    a_esc_off: assert property (s_q.setup[2][19:16] == 4'h0 |=> !o_ch_prio_up[2])
        else $error("escalation with zero period");
    a_pause_gate: assert property (!s_q.setup[0][13] |=> !o_ch_pause[0])
        else $error("pause without enable");
    a_done_gate: assert property (i_ch_seq_done[1] && s_q.setup[1][6] |=> o_ch_done_evt[1])
        else $error("done event missing");
    a_done_mute: assert property (!s_q.setup[1][6] |=> !o_ch_done_evt[1])
        else $error("done event while disabled");
    a_trig_sel: assert property (i_trig_evt[s_q.setup[2][1:0]] |=> o_ch_start[2])
        else $error("selected trigger did not start");
    a_sts_sticky: assert property (o_ch_done_evt[0] |=> s_q.sts[0])
        else $error("event status not set");
    a_irq_level: assert property (s_q.sts[0] && s_q.ien[0] |-> o_irq)
        else $error("interrupt not raised");
    a_rank_decode: assert property (o_ch_start_rank[1] == o_ch_start_addr[1][24:22])
        else $error("rank decode wrong");
    a_qos_tag: assert property (o_ch_qos[2] == s_q.setup[2][12:9])
        else $error("qos tag wrong");

    c_prio_raise: cover property (i_ch_waiting[0] ##1 $rose(o_ch_prio_up[0]));
    c_done_irq: cover property (o_ch_done_evt[2] ##1 o_irq);
    c_clear_race: cover property (i_wr && i_addr == 12'h1e4 && o_ch_done_evt[0]);
    c_pause: cover property ($rose(o_ch_pause[1]));
    c_cap_block: cover property (i_ch_inflight[2] >= 5'd8 ##1 !o_ch_issue_ok[2]);

    // Shared register port checks
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    a_ch1_store: assert property (
        i_wr && i_addr == OFS_CH1_END |=> o_ch1_end_addr == $past(i_wdata))
        else $error("channel 1 end write lost");

    a_ch1_keep: assert property (
        !(i_wr && i_addr == OFS_CH1_END) |=> $stable(o_ch1_end_addr))
        else $error("channel 1 end changed unasked");

    a_en_store: assert property (
        i_wr && i_addr == OFS_EVT_EN |=> s_q.ien == $past(i_wdata[2:0]))
        else $error("event enable write lost");

    a_sts_read: assert property (
        i_rd && i_addr == OFS_EVT_STS |=> o_rdata == {29'h0000_0000, $past(s_q.sts)})
        else $error("status read wrong");

    a_irq_off: assert property (!(|(s_q.sts & s_q.ien)) |-> !o_irq)
        else $error("interrupt without enabled status");

    // Per-channel checks; one copy each for channels 2 to 4
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        // Register offsets of this channel
        localparam logic [11:0] SET_OFS = 12'(OFS_CH2_SETUP + 12'(g) * OFS_CH_STRIDE);
        localparam logic [11:0] BEG_OFS = 12'(SET_OFS + 12'h004);
        localparam logic [11:0] FIN_OFS = 12'(SET_OFS + 12'h008);

        // Reserved positions never held
        a_rsvd_clear: assert property (
            (s_q.setup[g] & ~SETUP_MASK) == 32'h0000_0000)
            else $error("reserved setup bits held");
        // Setup word takes the masked write
        a_setup_store: assert property (
            i_wr && i_addr == SET_OFS |=> s_q.setup[g] == ($past(i_wdata) & SETUP_MASK))
            else $error("setup write lost");
        // Setup word only moves on its own write
        a_setup_keep: assert property (
            !(i_wr && i_addr == SET_OFS) |=> $stable(s_q.setup[g]))
            else $error("setup changed unasked");
        // Start address takes the write
        a_start_store: assert property (
            i_wr && i_addr == BEG_OFS |=> o_ch_start_addr[g] == $past(i_wdata))
            else $error("start write lost");
        // Start address holds otherwise
        a_start_keep: assert property (
            !(i_wr && i_addr == BEG_OFS) |=> $stable(o_ch_start_addr[g]))
            else $error("start changed unasked");
        // End address takes the write
        a_end_store: assert property (
            i_wr && i_addr == FIN_OFS |=> o_ch_end_addr[g] == $past(i_wdata))
            else $error("end write lost");
        // End address holds otherwise
        a_end_keep: assert property (
            !(i_wr && i_addr == FIN_OFS) |=> $stable(o_ch_end_addr[g]))
            else $error("end changed unasked");
        // Setup word read back a cycle later
        a_setup_read: assert property (
            i_rd && i_addr == SET_OFS |=> o_rdata == $past(s_q.setup[g]))
            else $error("setup read wrong");
        // End address read back a cycle later
        a_end_read: assert property (
            i_rd && i_addr == FIN_OFS |=> o_rdata == $past(s_q.rend[g]))
            else $error("end read wrong");
        // Below the floor of 8 issue is always allowed
        a_cap_floor: assert property (
            i_ch_inflight[g] < CAP_MIN |=> o_ch_issue_ok[g])
            else $error("issue refused below floor");
        // At a legal cap issue stops
        a_cap_limit: assert property (
            i_ch_inflight[g] >= o_ch_cap[g] && o_ch_cap[g] >= CAP_MIN |=> !o_ch_issue_ok[g])
            else $error("issue allowed at cap");
        // Zero period keeps priority down
        a_esc_zero: assert property (
            s_q.setup[g][ESC_LSB +: 4] == 4'h0 |=> !o_ch_prio_up[g])
            else $error("escalation with zero period");
        // No waiting work, no raised priority
        a_esc_idle: assert property (
            !i_ch_waiting[g] |=> !o_ch_prio_up[g])
            else $error("escalation while idle");
        // Priority only rises on a prescaler tick
        a_esc_tick: assert property (
            $rose(o_ch_prio_up[g]) |-> $past(i_esc_tick))
            else $error("escalation without tick");
        // Pause follows enable and page arrival
        a_pause_follow: assert property (
            1'b1 |=> o_ch_pause[g] == ($past(s_q.setup[g][PAGE_BIT]) && $past(i_ch_at_page[g])))
            else $error("pause mismatch");
        // Done event follows enable and completion
        a_done_follow: assert property (
            1'b1 |=> o_ch_done_evt[g] == ($past(s_q.setup[g][DONE_BIT]) && $past(i_ch_seq_done[g])))
            else $error("done event mismatch");
        // Selected trigger starts the channel
        a_trig_fire: assert property (
            i_trig_evt[s_q.setup[g][TRIG_LSB +: 2]] |=> o_ch_start[g])
            else $error("selected trigger missed");
        // Other triggers leave it alone
        a_trig_quiet: assert property (
            !i_trig_evt[s_q.setup[g][TRIG_LSB +: 2]] |=> !o_ch_start[g])
            else $error("start without selected trigger");
        // Physical bank and row of the end address
        a_end_decode: assert property (
            o_ch_end_bank[g] == o_ch_end_addr[g][21:18] && o_ch_end_row[g] == o_ch_end_addr[g][17:0])
            else $error("end decode wrong");
        // Mode output mirrors the setup bit
        a_mode_follow: assert property (
            o_ch_phys_mode[g] == s_q.setup[g][MODE_BIT])
            else $error("address mode wrong");
        // Each done event leaves its status bit set
        a_sts_set: assert property (
            o_ch_done_evt[g] |=> s_q.sts[g])
            else $error("status not set");
        // A clear with no new event drops the bit
        a_sts_clear: assert property (
            i_wr && i_addr == OFS_EVT_CLR && i_wdata[g] && !o_ch_done_evt[g] |=> !s_q.sts[g])
            else $error("status not cleared");
    end : g_chk

endmodule : scb_bank

// ===== scb_bank_test.sv
// Self-checking bench for the scrub channel configuration bank.
// Assumes one 50 MHz clock; all inputs driven by NBA at rising edges.
module scb_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scb_pkg::*;

    logic             clk, rst_n, wr, rd, esc, irq;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    wdata, rdata, ch1e, v;
    logic [3:0]       trig;
    logic [2:0]       wait_c, at_pg, sdone, ok, pup, pau, devt, phys, strt;
    logic [2:0][4:0]  infl, cap;
    logic [2:0][3:0]  qos, sbk, ebk;
    logic [2:0][31:0] sa, ea;
    logic [2:0][2:0]  srk, erk;
    logic [2:0][17:0] srw, erw;
    int               fail_count, check_count;

    scb_bank i_scb_bank (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_trig_evt(trig),
        .i_esc_tick(esc), .i_ch_waiting(wait_c), .i_ch_at_page(at_pg),
        .i_ch_seq_done(sdone), .i_ch_inflight(infl), .o_ch_cap(cap), .o_ch_issue_ok(ok),
        .o_ch_prio_up(pup), .o_ch_pause(pau), .o_ch_qos(qos), .o_ch_done_evt(devt),
        .o_ch_phys_mode(phys), .o_ch_start(strt), .o_ch_start_addr(sa),
        .o_ch_end_addr(ea), .o_ch_start_rank(srk), .o_ch_start_bank(sbk),
        .o_ch_start_row(srw), .o_ch_end_rank(erk), .o_ch_end_bank(ebk),
        .o_ch_end_row(erw), .o_ch1_end_addr(ch1e));

    // Free-running 20 ns clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // One-cycle write strobe; the edge after it lets the next strobe start clean
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask : rd_chk

    task automatic pulse(input int c, input logic [3:0] t, input logic e);
        @(posedge clk);
        if (c >= 0) sdone[c] <= 1'b1;
        trig <= t; esc <= e;
        @(posedge clk);
        sdone <= '0; trig <= '0; esc <= 1'b0;
        #1;
    endtask : pulse

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [11:0] b;
        {wr, rd, esc, addr, wdata, trig, wait_c, at_pg, sdone, infl} = '0;
        rst_n = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        for (int c = 0; c < 3; c++) begin
            b = OFS_CH2_SETUP + 12'(c) * OFS_CH_STRIDE;
            chk("cap", 32'h1f, 32'(cap[c]));
            rd_chk(b, RST_SETUP);
            rd_chk(b + 12'h4, RST_ADDR);
            rd_chk(b + 12'h8, RST_ADDR);
        end
        rd_chk(OFS_CH1_END, RST_ADDR);
        $display("test reset done");

        // Full writes: reserved bits drop, fields and decodes follow
        for (int c = 0; c < 3; c++) begin
            b = OFS_CH2_SETUP + 12'(c) * OFS_CH_STRIDE;
            v = 32'h0123_4567 ^ (32'h0155_0003 << c);
            wr_reg(b, 32'hffff_ffff);
            rd_chk(b, SETUP_MASK);
            chk("qos", 32'hf, 32'(qos[c]));
            chk("mode", 32'h1, 32'(phys[c]));
            wr_reg(b + 12'h4, v);
            wr_reg(b + 12'h8, ~v);
            rd_chk(b + 12'h4, v);
            rd_chk(b + 12'h8, ~v);
            chk("start", v, sa[c]);
            chk("end", ~v, ea[c]);
            chk("srank", 32'(v[24:22]), 32'(srk[c]));
            chk("sbank", 32'(v[21:18]), 32'(sbk[c]));
            chk("srow", 32'(v[17:0]), 32'(srw[c]));
            chk("erank", 32'(v[24:22] ^ 3'h7), 32'(erk[c]));
            chk("ebank", 32'(v[21:18] ^ 4'hf), 32'(ebk[c]));
            chk("erow", 32'(v[17:0] ^ 18'h3ffff), 32'(erw[c]));
            wr_reg(b, 32'h0);
            chk("sysmode", 32'h0, 32'(phys[c]));
            chk("sysaddr", v, sa[c]);
        end
        wr_reg(OFS_CH1_END, 32'ha5a5_5a5a);
        rd_chk(OFS_CH1_END, 32'ha5a5_5a5a);
        chk("ch1end", 32'ha5a5_5a5a, ch1e);
        wr_reg(12'h1fc, 32'hffff_ffff);
        rd_chk(12'h1fc, 32'h0);
        rd_chk(OFS_EVT_CLR, 32'h0);
        $display("test access done");

        // Done events: raise, mask, clear, and none with the bit off
        for (int c = 0; c < 3; c++) begin
            b = OFS_CH2_SETUP + 12'(c) * OFS_CH_STRIDE;
            wr_reg(b, 32'h40);
            wr_reg(OFS_EVT_EN, 32'(1 << c));
            pulse(c, 4'h0, 1'b0);
            chk("devt", 32'(1 << c), 32'(devt));
            step(1);
            chk("irq", 32'h1, 32'(irq));
            rd_chk(OFS_EVT_STS, 32'(1 << c));
            wr_reg(OFS_EVT_EN, 32'h0);
            chk("masked", 32'h0, 32'(irq));
            wr_reg(OFS_EVT_CLR, 32'(1 << c));
            rd_chk(OFS_EVT_STS, 32'h0);
            wr_reg(OFS_EVT_EN, 32'h7);
            wr_reg(b, 32'h0);
            pulse(c, 4'h0, 1'b0);
            chk("noevt", 32'h0, 32'(devt));
            step(1);
            chk("noirq", 32'h0, 32'(irq));
        end
        $display("test events done");

        // Every trigger select, and a foreign trigger ignored
        for (int s = 0; s < 4; s++) begin
            wr_reg(OFS_CH2_SETUP, 32'(s));
            pulse(-1, 4'(1 << s), 1'b0);
            chk("trig", 32'h1, 32'(strt[0]));
            pulse(-1, 4'(1 << ((s + 1) % 4)), 1'b0);
            chk("notrig", 32'h0, 32'(strt[0]));
        end
        $display("test trigger done");

        // Pause at page follows the enable bit
        wr_reg(OFS_CH3_SETUP, 32'h2000);
        @(posedge clk) at_pg <= 3'b010;
        step(2);
        chk("pause", 32'h2, 32'(pau));
        wr_reg(OFS_CH3_SETUP, 32'h0);
        step(1);
        chk("nopause", 32'h0, 32'(pau));
        @(posedge clk) at_pg <= 3'b000;
        $display("test pause done");

        // Escalation after two ticks, then zero disables it
        wr_reg(OFS_CH2_SETUP, 32'h0002_0000);
        @(posedge clk) wait_c <= 3'b001;
        pulse(-1, 4'h0, 1'b1);
        step(2);
        chk("early", 32'h0, 32'(pup[0]));
        pulse(-1, 4'h0, 1'b1);
        for (int n = 0; n < 3 && pup[0] !== 1'b1; n++) step(1);
        chk("prio", 32'h1, 32'(pup[0]));
        wr_reg(OFS_CH2_SETUP, 32'h0);
        repeat (4) pulse(-1, 4'h0, 1'b1);
        chk("disabled", 32'h0, 32'(pup[0]));
        @(posedge clk) wait_c <= 3'b000;
        $display("test escalation done");

        // Request cap: low values act as 8, top value 31
        wr_reg(OFS_CH4_SETUP, 32'h0300_0000);
        rd_chk(OFS_CH4_SETUP, 32'h0300_0000);
        chk("capf", 32'h3, 32'(cap[2]));
        @(posedge clk) infl[2] <= 5'd7;
        step(2);
        chk("cap8 ok", 32'h1, 32'(ok[2]));
        @(posedge clk) infl[2] <= 5'd8;
        step(2);
        chk("cap8 full", 32'h0, 32'(ok[2]));
        wr_reg(OFS_CH4_SETUP, RST_SETUP);
        @(posedge clk) infl[2] <= 5'd30;
        step(2);
        chk("cap31 ok", 32'h1, 32'(ok[2]));
        @(posedge clk) infl[2] <= 5'd31;
        step(2);
        chk("cap31 full", 32'h0, 32'(ok[2]));
        $display("test cap done");
        give_verdict();
    end
endmodule : scb_bank_test

// ===== scb_pkg.sv
// Constants and state type of the scrub channel configuration bank.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package scb_pkg;

    // Register port geometry
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    localparam int unsigned NCH = 3;   // channels 2, 3 and 4

    // Register offsets, byte addresses
    localparam logic [11:0] OFS_CH1_END   = 12'h188;
    localparam logic [11:0] OFS_CH2_SETUP = 12'h190;
    localparam logic [11:0] OFS_CH2_START = 12'h194;
    localparam logic [11:0] OFS_CH2_END   = 12'h198;
    localparam logic [11:0] OFS_CH3_SETUP = 12'h1a0;
    localparam logic [11:0] OFS_CH3_START = 12'h1a4;
    localparam logic [11:0] OFS_CH3_END   = 12'h1a8;
    localparam logic [11:0] OFS_CH4_SETUP = 12'h1b0;
    localparam logic [11:0] OFS_CH4_START = 12'h1b4;
    localparam logic [11:0] OFS_CH4_END   = 12'h1b8;
    localparam logic [11:0] OFS_EVT_STS   = 12'h1e0;
    localparam logic [11:0] OFS_EVT_CLR   = 12'h1e4;
    localparam logic [11:0] OFS_EVT_EN    = 12'h1e8;
    localparam logic [11:0] OFS_CH_STRIDE = 12'h010;

    // Reset values and setup write mask
    localparam logic [31:0] RST_SETUP = 32'h1f00_0000;
    localparam logic [31:0] RST_ADDR  = 32'h0000_0000;
    localparam logic [31:0] SETUP_MASK = 32'h1f0f_3e4b;

    // Field positions of the channel setup word
    localparam int unsigned CAP_LSB  = 24;
    localparam int unsigned ESC_LSB  = 16;
    localparam int unsigned PAGE_BIT = 13;
    localparam int unsigned QOS_LSB  = 9;
    localparam int unsigned DONE_BIT = 6;
    localparam int unsigned MODE_BIT = 3;
    localparam int unsigned TRIG_LSB = 0;
    localparam logic [4:0] CAP_MIN  = 5'h08;

    // Physical address fields
    localparam int unsigned RANK_LSB = 22;
    localparam int unsigned BANK_LSB = 18;
    localparam int unsigned ROW_LSB  = 0;

    typedef struct packed {
        logic [31:0]          ch1_end;
        logic [2:0][31:0]     setup;
        logic [2:0][31:0]     rstart;
        logic [2:0][31:0]     rend;
        logic [2:0]           sts;
        logic [2:0]           ien;
        logic                 irq;
        logic [31:0]          rdata;
        logic [2:0][3:0]      esc_cnt;
        logic [2:0]           prio_up;
        logic [2:0]           pause;
        logic [2:0]           start;
        logic [2:0]           done_evt;
        logic [2:0]           issue_ok;
    } scb_state_t;

endpackage : scb_pkg
